/* test/wrxrb_bank_test.sv */
// Bench for the receiver register bank, host model on the port.
// Assumes a pull-up on the open-drain interrupt pin.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module wrxrb_bank_test
   import wrxrb_pkg::*;
;
   logic        clk, resetn, rv, ep, rf, oe, on;
   logic [7:0]  rdat, ev, bc, er;
   wrxrb_req_t  req;
   wrxrb_meas_t meas;
   int          fail_count, n_tests, ep_n, rf_n;
   wire         irq_pin_n = oe ? 1'b1 : on;
   wrxrb_bank DUT (.clk(clk), .resetn(resetn), .req(req), .rdata(rdat),
      .rvalid(rv), .meas(meas), .irq_event(ev), .regulator_on_in(1'b0),
      .batt_charge(bc), .end_power_reason(er), .end_power_packet(ep),
      .regulator_flip(rf), .irq_n_out(on), .irq_n_oe(oe));
   wrxrb_host h (.clk(clk), .req(req), .rdata(rdat), .rvalid(rv));
   always @(posedge clk)
   begin
      if (ep === 1'b1) ep_n++;
      if (rf === 1'b1) rf_n++;
   end
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      h.rd(a, v);
      `CHK(v, e)
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [7:0] x);
      @(posedge clk);
      ev <= x;
      @(posedge clk);
      ev <= 8'h00;
      wt(2);
   endtask
   task automatic t_reset;
      `CHK(irq_pin_n, 1'b1)
      rchk(OFF_IRQ_ENABLE, 8'h10);
      rchk(OFF_RSVD_ENABLE, 8'h00);
      rchk(OFF_BATT_CHARGE, 8'h00);
      rchk(OFF_END_REASON, 8'h00);
      rchk(OFF_IRQ_STATUS, 8'h00);
      rchk(OFF_COMMAND, 8'h00);
   endtask
   task automatic t_regs;
      h.wr(OFF_IRQ_ENABLE, 8'hFF);
      rchk(OFF_IRQ_ENABLE, 8'h93);
      h.wr(OFF_RSVD_ENABLE, 8'hC3);
      rchk(OFF_RSVD_ENABLE, 8'hC3);
      h.wr(OFF_BATT_CHARGE, 8'hA5);
      rchk(OFF_BATT_CHARGE, 8'hA5);
      `CHK(bc, 8'hA5)
   endtask
   task automatic t_meas;
      logic [7:0] ad [13] = '{8'h3C, 8'h3D, 8'h40, 8'h41, 8'h44, 8'h45,
         8'h46, 8'h47, 8'h48, 8'h49, 8'h4B, 8'h4C, 8'h50};
      logic [7:0] ex [13] = '{8'hBC, 8'h0A, 8'hDE, 8'h09, 8'h34, 8'h12,
         8'h65, 8'h07, 8'hDC, 8'hFE, 8'h80, 8'h7F, 8'h00};
      meas <= '{12'hABC, 12'h9DE, 16'h1234, 12'h765, 16'hFEDC, 8'h80, 8'h7F};
      // Read-only place must ignore the write
      h.wr(OFF_IOUT_LOW, 8'h00);
      for (int i = 0; i < 13; i++)
         rchk(ad[i], ex[i]);
   endtask
   task automatic t_irq;
      h.wr(OFF_IRQ_ENABLE, 8'h00);
      pulse(8'h02);
      `CHK(irq_pin_n, 1'b1)
      rchk(OFF_IRQ_STATUS, 8'h02);
      h.wr(OFF_IRQ_ENABLE, 8'h02);
      wt(2);
      `CHK(irq_pin_n, 1'b0)
      pulse(8'h0C);
      rchk(OFF_IRQ_STATUS, 8'h06);
      wt(8);
      `CHK(irq_pin_n, 1'b0)
      h.wr(OFF_COMMAND, 8'h20);
      wt(2);
      `CHK(irq_pin_n, 1'b1)
      rchk(OFF_IRQ_STATUS, 8'h00);
      h.wr(OFF_IRQ_ENABLE, 8'h07);
      pulse(8'h04);
      `CHK(irq_pin_n, 1'b1)
      pulse(8'h01);
      `CHK(irq_pin_n, 1'b0)
      h.wr(OFF_COMMAND, 8'h20);
   endtask
   task automatic t_cmd;
      ep_n = 0;
      rf_n = 0;
      h.wr(OFF_END_REASON, 8'h3C);
      h.wr(OFF_COMMAND, 8'h08);
      wt(4);
      `CHK(ep_n, 1)
      `CHK(er, 8'h3C)
      h.wr(OFF_COMMAND, 8'h02);
      wt(4);
      `CHK(rf_n, 1)
      `CHK(ep_n, 1)
      rchk(OFF_COMMAND, 8'h00);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      resetn = 1'b0;
      ev = 8'h00;
      meas = '0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      wt(4);
      t_reset;
      t_regs;
      t_meas;
      t_irq;
      t_cmd;
      complete_run;
   end
   // About 120 cycles expected; stop far beyond that
   initial
   begin
      #400000;
      fail_count++;
      complete_run;
   end
endmodule // wrxrb_bank_test

/* test/wrxrb_host.sv */
// Host model: master of the byte register port.
// Assumes the bank samples the strobes on the rising clock.
`timescale 1ns/1ps
module wrxrb_host
   import wrxrb_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Register port
   output wrxrb_req_t      req,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid
);
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, v};
      @(posedge clk);
      // Released lines show junk, not the last value
      req <= '{1'b0, 1'b0, ~a, ~v};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1;
      v = (rvalid === 1'b1) ? rdata : 8'hXX;
   endtask
endmodule // wrxrb_host

/* verilog/wrxrb_bank.sv */
// Host register bank of a wireless power receiver.
// Assumes a byte register port (one-cycle rd/wr strobes) from a serial
// bus front end, measurements and events from the power stage.
//
// Overview of operation
// - Interrupt pin low when enabled status set
// - Enable bits mask sources; temp enable read-only
// - Battery charge byte held, forwarded unchanged
// - End-power reason stored, placed in packet
// - Output voltage 12-bit split, upper nibble zero
// - Rectifier voltage 12-bit split, upper nibble zero
// - Output current 16-bit, low byte first
// - Die temperature 12-bit split, low then high
// - Coil period 16-bit, low byte first
// - Alignment X and Y signed bytes
// - Command bit 5 releases interrupt pin
// - Command bit 3 sends one end-power packet
// - Command bit 1 flips regulator exactly once
// - Status bits 7,2,1,0 used; others zero
`timescale 1ns/1ps
module wrxrb_bank
   import wrxrb_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Register port
   input  wire wrxrb_req_t  req,
   output logic [7:0]       rdata,
   output logic             rvalid,
   // Power stage side
   input  wire wrxrb_meas_t meas,
   input  wire logic [7:0]  irq_event,
   input  wire logic        regulator_on_in,
   // Outputs to power stage and packet sender
   output logic [7:0]       batt_charge,
   output logic [7:0]       end_power_reason,
   output logic             end_power_packet,
   output logic             regulator_flip,
   // Interrupt pin, open drain
   output logic             irq_n_out,
   output logic             irq_n_oe
);
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] enable;
      logic [7:0] rsvd_en;
      logic [7:0] batt;
      logic [7:0] reason;
      logic [7:0] rdata;
      logic       rvalid;
      logic       send;
      logic       flip;
      logic       irq_oe;
   } wrxrb_state_t;

   wrxrb_state_t st_reg;
   wrxrb_state_t st_next;
   logic         rst_n;
   logic [7:0]   rd_mux;
   logic [7:0]   cmd_wr;

   wrxrb_sync u_sync (
      .clk         (clk),
      .resetn      (resetn),
      .resetn_sync (rst_n)
   );

   assign cmd_wr = (req.wr && req.addr == OFF_COMMAND) ? req.wdata : 8'h00;

   // Read multiplexer
   always_comb
   begin
      unique case (req.addr)
         OFF_IRQ_STATUS:  rd_mux = st_reg.status;
         OFF_IRQ_ENABLE:  rd_mux = st_reg.enable;
         OFF_RSVD_ENABLE: rd_mux = st_reg.rsvd_en;
         OFF_BATT_CHARGE: rd_mux = st_reg.batt;
         OFF_END_REASON:  rd_mux = st_reg.reason;
         OFF_VOUT_LOW:    rd_mux = meas.vout_code[7:0];
         OFF_VOUT_HIGH:   rd_mux = {4'h0, meas.vout_code[11:8]};
         OFF_RECTIFIER_VOLTAGE_LOW:   rd_mux = meas.rectifier_voltage_code[7:0];
         OFF_RECTIFIER_VOLTAGE_HIGH:
            rd_mux = {4'h0, meas.rectifier_voltage_code[11:8]};
         OFF_IOUT_LOW:    rd_mux = meas.output_current_ma[7:0];
         OFF_IOUT_HIGH:   rd_mux = meas.output_current_ma[15:8];
         OFF_TEMP_LOW:    rd_mux = meas.temp_code[7:0];
         OFF_TEMP_HIGH:   rd_mux = {4'h0, meas.temp_code[11:8]};
         OFF_PERIOD_LOW:  rd_mux = meas.coil_period_count[7:0];
         OFF_PERIOD_HIGH: rd_mux = meas.coil_period_count[15:8];
         OFF_ALIGN_X:     rd_mux = meas.align_x;
         OFF_ALIGN_Y:     rd_mux = meas.align_y;
         // Action bits are pulses, so the command byte always reads zero
         OFF_COMMAND:     rd_mux = 8'h00;
         default:         rd_mux = 8'h00;
      endcase
   end

   always_comb
   begin
      st_next        = st_reg;
      st_next.rvalid = req.rd;
      st_next.rdata  = req.rd ? rd_mux : st_reg.rdata;
      // Sticky status; new event wins over the clear in the same cycle
      if (cmd_wr[CMD_CLEAR_IRQ])
         st_next.status = 8'h00;
      st_next.status = st_next.status | (irq_event & IRQ_USED_MASK);
      if (req.wr && req.addr == OFF_IRQ_ENABLE)
         st_next.enable = (req.wdata & ENABLE_WR_MASK)
                        | (st_reg.enable & ~ENABLE_WR_MASK);
      if (req.wr && req.addr == OFF_RSVD_ENABLE)
         st_next.rsvd_en = req.wdata;
      if (req.wr && req.addr == OFF_BATT_CHARGE)
         st_next.batt = req.wdata;
      if (req.wr && req.addr == OFF_END_REASON)
         st_next.reason = req.wdata;
      // One-cycle action pulses, self-clearing
      st_next.send = cmd_wr[CMD_END_POWER];
      st_next.flip = cmd_wr[CMD_REG_FLIP];
      // Pin pulled low (enable low) while any enabled flag is set
      st_next.irq_oe = ~|(st_next.status & st_next.enable);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg         <= '0;
         st_reg.enable  <= ENABLE_RESET;
         st_reg.rsvd_en <= RSVD_EN_RESET;
         st_reg.batt    <= BATT_RESET;
         st_reg.reason  <= REASON_RESET;
         st_reg.irq_oe  <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   assign rdata            = st_reg.rdata;
   assign rvalid           = st_reg.rvalid;
   assign batt_charge      = st_reg.batt;
   assign end_power_reason = st_reg.reason;
   assign end_power_packet = st_reg.send;
   assign regulator_flip   = st_reg.flip;
   assign irq_n_out        = 1'b0;
   assign irq_n_oe         = st_reg.irq_oe;

   // Assertions
   irq_pin_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (|(st_reg.status & st_reg.enable)) == !irq_n_oe)
      else $error("irq pin disagrees with status and enable");
   temp_en_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.wr && req.addr == OFF_IRQ_ENABLE |=>
      st_reg.enable[BIT_OVER_TEMP] == $past(st_reg.enable[BIT_OVER_TEMP]))
      else $error("over-temperature enable changed by a write");
   batt_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.wr && req.addr == OFF_BATT_CHARGE |=>
      batt_charge == $past(req.wdata))
      else $error("battery byte not forwarded");
   reason_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(req.wr && req.addr == OFF_END_REASON) |=>
      $stable(end_power_reason))
      else $error("reason changed without a write");
   vout_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_VOUT_HIGH |=>
      rvalid && rdata == {4'h0, $past(meas.vout_code[11:8])})
      else $error("output voltage high byte wrong");
   iout_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_IOUT_HIGH |=>
      rdata == $past(meas.output_current_ma[15:8]))
      else $error("current high byte wrong");
   rect_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_RECTIFIER_VOLTAGE_HIGH |=>
      rdata == {4'h0, $past(meas.rectifier_voltage_code[11:8])})
      else $error("rectifier voltage high byte wrong");
   temp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_TEMP_HIGH |=>
      rdata == {4'h0, $past(meas.temp_code[11:8])})
      else $error("temperature high byte wrong");
   period_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_PERIOD_LOW |=>
      rdata == $past(meas.coil_period_count[7:0]))
      else $error("coil period low byte wrong");
   align_x_a: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_ALIGN_X |=>
      rdata == $past(meas.align_x))
      else $error("alignment X byte wrong");
   clear_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
      cmd_wr[CMD_CLEAR_IRQ] && irq_event == 8'h00 |=>
      irq_n_oe && st_reg.status == 8'h00)
      else $error("clear command did not release the pin");
   flip_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      cmd_wr[CMD_REG_FLIP] |=> regulator_flip)
      else $error("regulator flip not issued");
   sequence end_cmd_s;
      req.wr && req.addr == OFF_COMMAND && req.wdata[CMD_END_POWER];
   endsequence
   sequence one_pulse_s;
      end_power_packet ##1 !end_power_packet;
   endsequence
   end_once_a: assert property (@(posedge clk) disable iff (!rst_n)
      end_cmd_s ##1 !(req.wr && req.addr == OFF_COMMAND) |-> one_pulse_s)
      else $error("end-power request not a single packet");
   flip_once_a: assert property (@(posedge clk) disable iff (!rst_n)
      regulator_flip |=> !regulator_flip || $past(cmd_wr[CMD_REG_FLIP], 1))
      else $error("regulator flipped more than once");
   status_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_reg.status & ~IRQ_USED_MASK) == 8'h00)
      else $error("reserved status bit set");
   status_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_reg.status[BIT_VOUT_CHANGE] && !cmd_wr[CMD_CLEAR_IRQ] |=>
      st_reg.status[BIT_VOUT_CHANGE])
      else $error("status flag dropped without clear");
endmodule // wrxrb_bank

/* verilog/wrxrb_pkg.sv */
// Package for the receiver host register bank: offsets, fields, resets.
// Assumes a byte-wide register port driven by a serial-bus front end.
package wrxrb_pkg;

   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h36;
   localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h38;
   localparam logic [7:0] OFF_RSVD_ENABLE  = 8'h39;
   localparam logic [7:0] OFF_BATT_CHARGE  = 8'h3A;
   localparam logic [7:0] OFF_END_REASON   = 8'h3B;
   localparam logic [7:0] OFF_VOUT_LOW     = 8'h3C;
   localparam logic [7:0] OFF_VOUT_HIGH    = 8'h3D;
   localparam logic [7:0] OFF_RECTIFIER_VOLTAGE_LOW    = 8'h40;
   localparam logic [7:0] OFF_RECTIFIER_VOLTAGE_HIGH   = 8'h41;
   localparam logic [7:0] OFF_IOUT_LOW     = 8'h44;
   localparam logic [7:0] OFF_IOUT_HIGH    = 8'h45;
   localparam logic [7:0] OFF_TEMP_LOW     = 8'h46;
   localparam logic [7:0] OFF_TEMP_HIGH    = 8'h47;
   localparam logic [7:0] OFF_PERIOD_LOW   = 8'h48;
   localparam logic [7:0] OFF_PERIOD_HIGH  = 8'h49;
   localparam logic [7:0] OFF_ALIGN_X      = 8'h4B;
   localparam logic [7:0] OFF_ALIGN_Y      = 8'h4C;
   localparam logic [7:0] OFF_COMMAND      = 8'h4E;

   // Interrupt bit positions, shared by status and enable
   localparam int BIT_VOUT_CHANGE = 7;
   localparam int BIT_OVER_TEMP   = 2;
   localparam int BIT_RECT_OV     = 1;
   localparam int BIT_OVERCURRENT = 0;
   localparam logic [7:0] IRQ_USED_MASK   = 8'h87;
   localparam logic [7:0] ENABLE_WR_MASK  = 8'h83;
   localparam logic [7:0] ENABLE_RESET    = 8'h10;
   localparam logic [7:0] RSVD_EN_RESET   = 8'h00;
   localparam logic [7:0] BATT_RESET      = 8'h00;
   localparam logic [7:0] REASON_RESET    = 8'h00;

   // Command bits
   localparam int CMD_CLEAR_IRQ  = 5;
   localparam int CMD_END_POWER  = 3;
   localparam int CMD_REG_FLIP   = 1;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } wrxrb_req_t;

   typedef struct packed {
      logic [11:0] vout_code;
      logic [11:0] rectifier_voltage_code;
      logic [15:0] output_current_ma;
      logic [11:0] temp_code;
      logic [15:0] coil_period_count;
      logic [7:0]  align_x;
      logic [7:0]  align_y;
   } wrxrb_meas_t;

endpackage

/* verilog/wrxrb_sync.sv */
// Two-stage synchroniser used to release the active-low reset.
// Assumes one clock; assertion is asynchronous, release is clocked.
`timescale 1ns/1ps
module wrxrb_sync
   import wrxrb_pkg::*;
(
   // Clock and raw reset
   input  wire logic clk,
   input  wire logic resetn,
   // Released reset
   output logic      resetn_sync
);
   logic [1:0] stage_reg;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         stage_reg <= 2'h0;
      else
         stage_reg <= {stage_reg[0], 1'b1};
   end

   assign resetn_sync = stage_reg[1];
endmodule // wrxrb_sync
